// >>> include/cdac_regs.svh
// Register offsets, field positions and reset values for the converter pair
// Assumes an 8-bit special-function register bus with 8-bit addresses
`ifndef CDAC_REGS_SVH
`define CDAC_REGS_SVH
`define CDAC_ADDR_DATA0 8'h96
`define CDAC_ADDR_CTRL0 8'hb9
`define CDAC_ADDR_CTRL1 8'hd7
`define CDAC_ADDR_DATA1 8'hdd
`define CDAC_EN_BIT 7
`define CDAC_SRC_HI 6
`define CDAC_SRC_LO 4
`define CDAC_CSC_BIT 3
`define CDAC_UNUSED_BIT 2
`define CDAC_FS_HI 1
`define CDAC_FS_LO 0
`define CDAC_CTRL_RST 8'h70
`define CDAC_DATA_RST 8'h00
`define CDAC_CTRL_WMASK 8'hfb
`define CDAC_PIN0 6
`define CDAC_PIN1 7
`endif

// >>> include/cdac_pkg.sv
// Types shared by the converter control files
// Assumes nothing beyond a SystemVerilog compiler
package cdac_pkg;
	typedef enum logic [2:0] {
		CDAC_SRC_T0,
		CDAC_SRC_T1,
		CDAC_SRC_T2,
		CDAC_SRC_T3,
		CDAC_SRC_RISE,
		CDAC_SRC_FALL,
		CDAC_SRC_BOTH,
		CDAC_SRC_WRITE
	} cdac_src_t;
endpackage

// >>> core/cdac_chan.sv
// One converter channel: control and data registers, pending word, latch
// Assumes single-cycle bus strobes and event pulses synchronous to clk
`timescale 1ns/1ns
`include "cdac_regs.svh"
module cdac_chan #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ctrl_wr,
	input wire logic data_wr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [3:0] tmr_ovf,
	input wire logic strobe_rise,
	input wire logic strobe_fall,
	output logic [WIDTH-1:0] ctrl_q,
	output logic [WIDTH-1:0] data_q,
	output logic [WIDTH-1:0] latch_q
);
	import cdac_pkg::*;
	logic [WIDTH-1:0] ctrl_reg;
	logic [WIDTH-1:0] data_reg;
	logic [WIDTH-1:0] latch_reg;
	logic [WIDTH-1:0] latch_next;
	logic event_hit;
	logic write_mode;
	cdac_src_t src;

	assign src = cdac_src_t'(ctrl_reg[`CDAC_SRC_HI:`CDAC_SRC_LO]); // R2
	assign write_mode = (src == CDAC_SRC_WRITE);
	always_comb begin
		case (src)
			CDAC_SRC_T0: event_hit = tmr_ovf[0]; // R3
			CDAC_SRC_T1: event_hit = tmr_ovf[1]; // R3
			CDAC_SRC_T2: event_hit = tmr_ovf[2]; // R3
			CDAC_SRC_T3: event_hit = tmr_ovf[3]; // R3
			CDAC_SRC_RISE: event_hit = strobe_rise; // R4
			CDAC_SRC_FALL: event_hit = strobe_fall; // R4
			CDAC_SRC_BOTH: event_hit = strobe_rise | strobe_fall; // R4
			default: event_hit = 1'b0;
		endcase
	end
	// Write mode copies the incoming word; other modes copy the held word
	assign latch_next = (write_mode && data_wr) ? wdata : // R5 R16
		(event_hit ? data_reg : latch_reg); // R15

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `CDAC_CTRL_RST;
			data_reg <= `CDAC_DATA_RST;
			latch_reg <= `CDAC_DATA_RST;
		end else begin
			if (ctrl_wr)
				ctrl_reg <= wdata & `CDAC_CTRL_WMASK; // R1 R6 R7 R8
			if (data_wr)
				data_reg <= wdata; // R9
			latch_reg <= latch_next;
		end
	end
	assign ctrl_q = ctrl_reg;
	assign data_q = data_reg;
	assign latch_q = latch_reg;

	chk_unused_bit_zero: assert property (@(posedge clk) // R7
		disable iff (rst)
		ctrl_reg[`CDAC_UNUSED_BIT] == 1'b0)
		else $error("unused control bit set");
	chk_write_mode_latch: assert property (@(posedge clk) // R16
		disable iff (rst)
		(write_mode && data_wr) |=> latch_reg == $past(wdata))
		else $error("write mode latch missed");
	chk_timer_hold: assert property (@(posedge clk) // R15
		disable iff (rst)
		(!write_mode && !event_hit) |=> $stable(latch_reg))
		else $error("latch moved without event");
	chk_event_copy: assert property (@(posedge clk) // R3
		disable iff (rst)
		(!write_mode && event_hit) |=> latch_reg == $past(data_reg))
		else $error("event did not copy data");
endmodule

// >>> core/cdac_ctrl.sv
// Top of the dual current converter control: bus decode, strobe, pins
// Assumes a one-cycle register strobe bus and timer overflow pulses on MCLK
`timescale 1ns/1ns
`include "cdac_regs.svh"
// Behaviour
// R1: Control bit 7 enables the channel
// R2: Bits 6-4 select the update source
// R3: Sources 000-011 update on timer overflows
// R4: Sources 100-110 update on strobe edges
// R5: Source 111 updates on data write
// R6: Bit 3 selects constant supply current
// R7: Bit 2 reads zero, ignores writes
// R8: Bits 1-0 select full-scale current
// R9: Readable writable 8-bit data register
// R10: Second identical independent channel
// R11: Channel 0 on port bit 6, 1 on 7
// R12: Disabled channel leaves pin as GPIO
// R13: Enabled channel cuts driver, pull-up, connects
// R14: Software should skip converter pins in crossbar
// R15: Event modes hold word until event
// R16: Write mode latches right after write
// R17: Strobe synchronised, edges give one pulse
module cdac_ctrl #(
	parameter int WIDTH = 8
) (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [WIDTH-1:0] SFR_WDATA,
	output logic [WIDTH-1:0] SFR_RDATA,
	output logic SFR_HIT,
	input wire logic [3:0] TMR_OVF,
	input wire logic CONVERSION_STROBE_PIN,
	input wire logic [7:0] P1_GPIO_OUT,
	input wire logic [7:0] P1_GPIO_OE,
	input wire logic [7:0] P1_GPIO_PULLUP,
	output logic [7:0] P1_OUT,
	output logic [7:0] P1_OE,
	output logic [7:0] P1_PULLUP,
	output logic [7:0] P1_ANALOG_SEL,
	output logic CHANNEL0_ENABLE,
	output logic [WIDTH-1:0] CHANNEL0_WORD,
	output logic CHANNEL0_CONST_SUPPLY,
	output logic [1:0] CHANNEL0_FULLSCALE_SEL,
	output logic CHANNEL1_ENABLE,
	output logic [WIDTH-1:0] CHANNEL1_WORD,
	output logic CHANNEL1_CONST_SUPPLY,
	output logic [1:0] CHANNEL1_FULLSCALE_SEL
);
	import cdac_pkg::*;
	logic strobe_meta_reg;
	logic strobe_sync_reg;
	logic strobe_last_reg;
	wire strobe_rise;
	wire strobe_fall;
	wire [1:0] ctrl_sel;
	wire [1:0] data_sel;
	wire [WIDTH-1:0] ctrl_q [2];
	wire [WIDTH-1:0] data_q [2];
	wire [WIDTH-1:0] latch_q [2];
	wire [1:0] chan_en;
	wire hit;
	logic [WIDTH-1:0] rdata_next;
	logic [7:0] mask_next;
	logic [7:0] out_next;
	logic [7:0] oe_next;
	logic [7:0] pu_next;

	// Only the second and third stages feed the edge detector
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			strobe_meta_reg <= 1'b0;
			strobe_sync_reg <= 1'b0;
			strobe_last_reg <= 1'b0;
		end else begin
			strobe_meta_reg <= CONVERSION_STROBE_PIN; // R17
			strobe_sync_reg <= strobe_meta_reg; // R17
			strobe_last_reg <= strobe_sync_reg;
		end
	end
	assign strobe_rise = strobe_sync_reg & ~strobe_last_reg; // R17
	assign strobe_fall = ~strobe_sync_reg & strobe_last_reg; // R17

	assign ctrl_sel[0] = (SFR_ADDR == `CDAC_ADDR_CTRL0);
	assign ctrl_sel[1] = (SFR_ADDR == `CDAC_ADDR_CTRL1);
	assign data_sel[0] = (SFR_ADDR == `CDAC_ADDR_DATA0);
	assign data_sel[1] = (SFR_ADDR == `CDAC_ADDR_DATA1);
	assign hit = |{ctrl_sel, data_sel};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_chan
			cdac_chan #(.WIDTH(WIDTH)) u_chan ( // R10
				.clk(MCLK),
				.rst(SYS_RST),
				.ctrl_wr(SFR_WR & ctrl_sel[g]),
				.data_wr(SFR_WR & data_sel[g]),
				.wdata(SFR_WDATA),
				.tmr_ovf(TMR_OVF),
				.strobe_rise(strobe_rise),
				.strobe_fall(strobe_fall),
				.ctrl_q(ctrl_q[g]),
				.data_q(data_q[g]),
				.latch_q(latch_q[g])
			);
			assign chan_en[g] = ctrl_q[g][`CDAC_EN_BIT]; // R1
		end
	endgenerate

	// Unmapped addresses read zero
	always_comb begin
		rdata_next = '0;
		if (ctrl_sel[0])
			rdata_next = ctrl_q[0];
		else if (ctrl_sel[1])
			rdata_next = ctrl_q[1];
		else if (data_sel[0])
			rdata_next = data_q[0]; // R9
		else if (data_sel[1])
			rdata_next = data_q[1]; // R9
	end

	// Pin takeover: enabled channel forces driver and pull-up off
	always_comb begin
		mask_next = 8'h00;
		mask_next[`CDAC_PIN0] = chan_en[0]; // R11
		mask_next[`CDAC_PIN1] = chan_en[1]; // R11
		out_next = P1_GPIO_OUT & ~mask_next; // R12
		oe_next = P1_GPIO_OE & ~mask_next; // R13
		pu_next = P1_GPIO_PULLUP & ~mask_next; // R13
	end

	// Outputs registered; pin takeover lags the enable write by one cycle
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			SFR_RDATA <= '0;
			SFR_HIT <= 1'b0;
			P1_OUT <= 8'h00;
			P1_OE <= 8'h00;
			P1_PULLUP <= 8'h00;
			P1_ANALOG_SEL <= 8'h00;
		end else begin
			SFR_RDATA <= SFR_RD ? rdata_next : '0;
			SFR_HIT <= (SFR_RD | SFR_WR) & hit;
			P1_OUT <= out_next;
			P1_OE <= oe_next; // R13
			P1_PULLUP <= pu_next; // R13
			P1_ANALOG_SEL <= mask_next; // R13
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			CHANNEL0_ENABLE <= 1'b0;
			CHANNEL0_WORD <= '0;
			CHANNEL0_CONST_SUPPLY <= 1'b0;
			CHANNEL0_FULLSCALE_SEL <= 2'h0;
			CHANNEL1_ENABLE <= 1'b0;
			CHANNEL1_WORD <= '0;
			CHANNEL1_CONST_SUPPLY <= 1'b0;
			CHANNEL1_FULLSCALE_SEL <= 2'h0;
		end else begin
			CHANNEL0_ENABLE <= chan_en[0]; // R1
			CHANNEL0_WORD <= latch_q[0];
			CHANNEL0_CONST_SUPPLY <= ctrl_q[0][`CDAC_CSC_BIT]; // R6
			CHANNEL0_FULLSCALE_SEL <= ctrl_q[0][`CDAC_FS_HI:`CDAC_FS_LO]; // R8
			CHANNEL1_ENABLE <= chan_en[1]; // R1
			CHANNEL1_WORD <= latch_q[1];
			CHANNEL1_CONST_SUPPLY <= ctrl_q[1][`CDAC_CSC_BIT]; // R6
			CHANNEL1_FULLSCALE_SEL <= ctrl_q[1][`CDAC_FS_HI:`CDAC_FS_LO]; // R8
		end
	end

	// Strobe edge detector
	chk_strobe_rise_pulse: assert property (@(posedge MCLK) // R17
		disable iff (SYS_RST)
		strobe_rise |=> !strobe_rise)
		else $error("rise pulse too long");
	chk_strobe_sync_delay: assert property (@(posedge MCLK) // R17
		disable iff (SYS_RST)
		$rose(CONVERSION_STROBE_PIN) ##1 CONVERSION_STROBE_PIN
		|=> strobe_rise)
		else $error("strobe edge not seen in time");
	chk_strobe_fall_pulse: assert property (@(posedge MCLK) // R17
		disable iff (SYS_RST)
		strobe_fall |=> !strobe_fall)
		else $error("fall pulse too long");
	chk_strobe_fall_delay: assert property (@(posedge MCLK) // R17
		disable iff (SYS_RST)
		$fell(CONVERSION_STROBE_PIN) ##1 !CONVERSION_STROBE_PIN
		|=> strobe_fall)
		else $error("falling strobe edge not seen in time");

	// Pin takeover; reset edge skipped as registers hold reset values there
	chk_pin_takeover: assert property (@(posedge MCLK) // R13
		disable iff (SYS_RST)
		chan_en[0] |=> !P1_OE[`CDAC_PIN0] && !P1_PULLUP[`CDAC_PIN0]
		&& !P1_OUT[`CDAC_PIN0] && P1_ANALOG_SEL[`CDAC_PIN0])
		else $error("pin 6 still driven");
	chk_pin_takeover1: assert property (@(posedge MCLK) // R13
		disable iff (SYS_RST)
		chan_en[1] |=> !P1_OE[`CDAC_PIN1] && !P1_PULLUP[`CDAC_PIN1]
		&& !P1_OUT[`CDAC_PIN1] && P1_ANALOG_SEL[`CDAC_PIN1])
		else $error("pin 7 still driven");
	chk_gpio_pass: assert property (@(posedge MCLK) // R12
		disable iff (SYS_RST)
		!SYS_RST && !chan_en[1] |=>
		P1_OE[`CDAC_PIN1] == $past(P1_GPIO_OE[`CDAC_PIN1]))
		else $error("pin 7 not plain gpio");
	chk_gpio_pass0: assert property (@(posedge MCLK) // R12
		disable iff (SYS_RST)
		!SYS_RST && !chan_en[0] |=>
		P1_PULLUP[`CDAC_PIN0] == $past(P1_GPIO_PULLUP[`CDAC_PIN0]))
		else $error("pin 6 pull-up not plain gpio");
	chk_analog_only: assert property (@(posedge MCLK) // R11
		disable iff (SYS_RST)
		P1_ANALOG_SEL[`CDAC_PIN0-1:0] == '0)
		else $error("analog select on a plain pin");
	chk_out_pass: assert property (@(posedge MCLK) // R12
		disable iff (SYS_RST)
		!SYS_RST |=>
		((P1_OUT ^ $past(P1_GPIO_OUT)) & ~P1_ANALOG_SEL) == 8'h00)
		else $error("gpio output level not passed");
	chk_pu_pass: assert property (@(posedge MCLK) // R12
		disable iff (SYS_RST)
		!SYS_RST |=>
		((P1_PULLUP ^ $past(P1_GPIO_PULLUP)) & ~P1_ANALOG_SEL) == 8'h00)
		else $error("gpio pull-up not passed");
	chk_oe_pass: assert property (@(posedge MCLK) // R12
		disable iff (SYS_RST)
		!SYS_RST |=>
		((P1_OE ^ $past(P1_GPIO_OE)) & ~P1_ANALOG_SEL) == 8'h00)
		else $error("gpio output enable not passed");
	chk_analog_sel: assert property (@(posedge MCLK) // R11
		disable iff (SYS_RST)
		!SYS_RST |=> P1_ANALOG_SEL[`CDAC_PIN0] == $past(chan_en[0])
		&& P1_ANALOG_SEL[`CDAC_PIN1] == $past(chan_en[1]))
		else $error("analog select does not follow enable");

	// Channel outputs lag their source register by one edge
	chk_en0_copy: assert property (@(posedge MCLK) // R1
		disable iff (SYS_RST)
		!SYS_RST |=> CHANNEL0_ENABLE == $past(chan_en[0]))
		else $error("channel 0 enable not copied");
	chk_en1_copy: assert property (@(posedge MCLK) // R1
		disable iff (SYS_RST)
		!SYS_RST |=> CHANNEL1_ENABLE == $past(chan_en[1]))
		else $error("channel 1 enable not copied");
	chk_csc0_copy: assert property (@(posedge MCLK) // R6
		disable iff (SYS_RST)
		!SYS_RST |=>
		CHANNEL0_CONST_SUPPLY == $past(ctrl_q[0][`CDAC_CSC_BIT]))
		else $error("channel 0 supply mode not copied");
	chk_csc1_copy: assert property (@(posedge MCLK) // R6
		disable iff (SYS_RST)
		!SYS_RST |=>
		CHANNEL1_CONST_SUPPLY == $past(ctrl_q[1][`CDAC_CSC_BIT]))
		else $error("channel 1 supply mode not copied");
	chk_fs0_copy: assert property (@(posedge MCLK) // R8
		disable iff (SYS_RST)
		!SYS_RST |=> CHANNEL0_FULLSCALE_SEL ==
		$past(ctrl_q[0][`CDAC_FS_HI:`CDAC_FS_LO]))
		else $error("channel 0 full scale not copied");
	chk_fs1_copy: assert property (@(posedge MCLK) // R8
		disable iff (SYS_RST)
		!SYS_RST |=> CHANNEL1_FULLSCALE_SEL ==
		$past(ctrl_q[1][`CDAC_FS_HI:`CDAC_FS_LO]))
		else $error("channel 1 full scale not copied");
	chk_word0_copy: assert property (@(posedge MCLK) // R15
		disable iff (SYS_RST)
		!SYS_RST |=> CHANNEL0_WORD == $past(latch_q[0]))
		else $error("channel 0 word not copied");
	chk_word1_copy: assert property (@(posedge MCLK) // R10
		disable iff (SYS_RST)
		!SYS_RST |=> CHANNEL1_WORD == $past(latch_q[1]))
		else $error("channel 1 word not copied");

	// Register bus
	chk_ctrl_readback: assert property (@(posedge MCLK) // R10
		disable iff (SYS_RST)
		(SFR_WR && ctrl_sel[1]) ##1 (SFR_RD && ctrl_sel[1] && !SFR_WR)
		|=> SFR_RDATA == ($past(SFR_WDATA, 2) & `CDAC_CTRL_WMASK))
		else $error("control readback wrong");
	chk_ctrl0_write: assert property (@(posedge MCLK) // R1
		disable iff (SYS_RST)
		SFR_WR && ctrl_sel[0] |=>
		ctrl_q[0] == ($past(SFR_WDATA) & `CDAC_CTRL_WMASK))
		else $error("control 0 write lost");
	chk_data1_write: assert property (@(posedge MCLK) // R10
		disable iff (SYS_RST)
		SFR_WR && data_sel[1] |=> data_q[1] == $past(SFR_WDATA))
		else $error("data 1 write lost");
	chk_read_data0: assert property (@(posedge MCLK) // R9
		disable iff (SYS_RST)
		SFR_RD && data_sel[0] |=> SFR_RDATA == $past(data_q[0]))
		else $error("data 0 read wrong");
	chk_read_data1: assert property (@(posedge MCLK) // R9
		disable iff (SYS_RST)
		SFR_RD && data_sel[1] |=> SFR_RDATA == $past(data_q[1]))
		else $error("data 1 read wrong");
	chk_read_unused: assert property (@(posedge MCLK) // R7
		disable iff (SYS_RST)
		SFR_RD && |ctrl_sel |=> SFR_RDATA[`CDAC_UNUSED_BIT] == 1'b0)
		else $error("unused bit read as one");
	chk_read_idle: assert property (@(posedge MCLK) // R9
		disable iff (SYS_RST)
		!SFR_RD |=> SFR_RDATA == '0)
		else $error("read data left standing");
	chk_unmapped: assert property (@(posedge MCLK) // R9
		disable iff (SYS_RST)
		(SFR_RD || SFR_WR) && !hit |=> SFR_RDATA == '0 && !SFR_HIT)
		else $error("unmapped access answered");
	chk_hit_pulse: assert property (@(posedge MCLK) // R9
		disable iff (SYS_RST)
		(SFR_RD || SFR_WR) && hit |=> SFR_HIT)
		else $error("mapped access not flagged");
endmodule

// >>> test/cdac_evt_model.sv
// Far-side model: timer overflow pulses and the external strobe pin
// Assumes requests from the bench change just after rising clk
`timescale 1ns/1ns
module cdac_evt_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] ovf_req,
	input wire logic pin_req,
	output logic [3:0] tmr_ovf,
	output logic strobe_pin
);
	logic [3:0] req_prev;
	// Overflows are single-cycle pulses, even if a request is held
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_prev <= 4'h0;
			tmr_ovf <= 4'h0;
			strobe_pin <= 1'b0;
		end else begin
			req_prev <= ovf_req;
			tmr_ovf <= ovf_req & ~req_prev;
			strobe_pin <= pin_req;
		end
	end
endmodule

// >>> test/test_cdac_ctrl.sv
// Bench for the converter pair control: register bus, events, pins
// Assumes cdac_ctrl with its one-cycle strobe bus and the event model
`timescale 1ns/1ns
`include "cdac_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_cdac_ctrl;
	logic MCLK = 0, SYS_RST = 1, SFR_WR = 0, SFR_RD = 0, pin_req = 0;
	logic [7:0] SFR_ADDR = 0, SFR_WDATA = 0, d, prev, rdata;
	// Port latch intent; converter pins 6 and 7 also driven, so takeover shows
	logic [7:0] gpio_out = 8'hc5, gpio_oe = 8'hdb, gpio_pu = 8'he7;
	logic [3:0] ovf_req = 0, ovf;
	logic strobe, hit, en0, en1, cs0, cs1;
	logic [7:0] p1_out, p1_oe, p1_pu, p1_an, word0, word1;
	logic [1:0] fs0, fs1;
	int fails = 0, n_compared = 0, cyc = 0;
	always #2 MCLK = ~MCLK;
	cdac_evt_model partner (.clk(MCLK), .rst(SYS_RST), .ovf_req(ovf_req),
		.pin_req(pin_req), .tmr_ovf(ovf), .strobe_pin(strobe));
	cdac_ctrl DUT (.MCLK(MCLK), .SYS_RST(SYS_RST), .SFR_ADDR(SFR_ADDR),
		.SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
		.SFR_RDATA(rdata), .SFR_HIT(hit), .TMR_OVF(ovf),
		.CONVERSION_STROBE_PIN(strobe), .P1_GPIO_OUT(gpio_out),
		.P1_GPIO_OE(gpio_oe), .P1_GPIO_PULLUP(gpio_pu), .P1_OUT(p1_out),
		.P1_OE(p1_oe), .P1_PULLUP(p1_pu), .P1_ANALOG_SEL(p1_an),
		.CHANNEL0_ENABLE(en0), .CHANNEL0_WORD(word0),
		.CHANNEL0_CONST_SUPPLY(cs0), .CHANNEL0_FULLSCALE_SEL(fs0),
		.CHANNEL1_ENABLE(en1), .CHANNEL1_WORD(word1),
		.CHANNEL1_CONST_SUPPLY(cs1), .CHANNEL1_FULLSCALE_SEL(fs1));
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge MCLK);
		SFR_ADDR <= a; SFR_WDATA <= v; SFR_WR <= 1'b1;
		@(posedge MCLK);
		SFR_WR <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge MCLK);
		SFR_ADDR <= a; SFR_RD <= 1'b1;
		@(posedge MCLK);
		SFR_RD <= 1'b0;
		#1 `CHK(rdata, exp)
	endtask
	// Write then read back at the very next edge
	task wr_rd(input logic [7:0] a, input logic [7:0] v,
		input logic [7:0] exp);
		@(posedge MCLK);
		SFR_ADDR <= a;
		SFR_WDATA <= v;
		SFR_WR <= 1'b1;
		@(posedge MCLK);
		SFR_WR <= 1'b0;
		SFR_RD <= 1'b1;
		@(posedge MCLK);
		SFR_RD <= 1'b0;
		#1 `CHK(rdata, exp)
	endtask
	task idle(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task pulse(input int k);
		@(posedge MCLK);
		ovf_req <= 4'h1 << k;
		@(posedge MCLK);
		ovf_req <= 4'h0;
		idle(4);
	endtask
	task wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Generous ceiling; the full run needs well under 600 cycles
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			wrap_up;
		end
	end
	initial begin
		repeat (2) @(posedge MCLK);
		SYS_RST <= 1'b0;
		rd_chk(`CDAC_ADDR_CTRL0, 8'h70);
		rd_chk(`CDAC_ADDR_CTRL1, 8'h70);
		rd_chk(`CDAC_ADDR_DATA0, 8'h00);
		rd_chk(`CDAC_ADDR_DATA1, 8'h00);
		`CHK(hit, 1'b1)
		rd_chk(8'h00, 8'h00);
		`CHK(hit, 1'b0)
		`CHK({p1_oe, p1_pu, p1_out, p1_an}, 32'hdbe7c500)
		$display("test reset done");
		wr(`CDAC_ADDR_CTRL0, 8'hff);
		rd_chk(`CDAC_ADDR_CTRL0, 8'hfb);
		idle(1);
		`CHK(rdata, 8'h00)
		`CHK({en0, cs0, fs0}, 4'hf)
		`CHK({p1_oe, p1_pu, p1_out, p1_an}, 32'h9ba78540)
		wr(`CDAC_ADDR_CTRL0, 8'hf2);
		idle(1);
		`CHK({cs0, fs0}, 3'h2)
		`CHK(cs0, 1'b0)
		wr(`CDAC_ADDR_DATA0, 8'h3c);
		idle(1);
		`CHK(word0, 8'h3c)
		rd_chk(`CDAC_ADDR_DATA0, 8'h3c);
		$display("test control done");
		prev = 8'h3c;
		for (int k = 0; k < 4; k++) begin
			wr(`CDAC_ADDR_CTRL0, {1'b1, 3'(k), 4'h0});
			d = 8'h10 + 8'(k);
			wr(`CDAC_ADDR_DATA0, d);
			idle(3);
			`CHK(word0, prev)
			pulse((k + 1) % 4);
			`CHK(word0, prev)
			pulse(k);
			`CHK(word0, d)
			prev = d;
		end
		$display("test timers done");
		for (int m = 4; m < 7; m++) begin
			wr(`CDAC_ADDR_CTRL0, {1'b1, 3'(m), 4'h0});
			d = 8'h40 + 8'(m);
			wr(`CDAC_ADDR_DATA0, d);
			pin_req <= 1'b1;
			idle(8);
			if (m != 5) prev = d;
			`CHK(word0, prev)
			wr(`CDAC_ADDR_DATA0, ~d);
			pin_req <= 1'b0;
			idle(8);
			if (m != 4) prev = ~d;
			`CHK(word0, prev)
		end
		$display("test strobe done");
		wr_rd(`CDAC_ADDR_CTRL1, 8'h8e, 8'h8a);
		wr(`CDAC_ADDR_CTRL1, 8'hfd);
		rd_chk(`CDAC_ADDR_CTRL1, 8'hf9);
		`CHK({en1, cs1, fs1}, 4'hd)
		wr(`CDAC_ADDR_DATA1, 8'ha5);
		idle(2);
		`CHK(word1, 8'ha5)
		`CHK(word0, prev)
		`CHK({p1_oe, p1_an}, 16'h1bc0)
		wr(`CDAC_ADDR_CTRL0, 8'h70);
		idle(2);
		`CHK({en0, p1_oe, p1_pu, p1_an}, 25'h05b6780)
		$display("test channel1 done");
		wrap_up;
	end
endmodule
